// ### pkg/cfg_select_pkg.sv
package cfg_select_pkg;

  // Configuration source, one-hot.
  typedef enum logic [4:0] {
    SRC_SMBUS_A   = 5'h01,
    SRC_SMBUS_B   = 5'h02,
    SRC_DEFAULT   = 5'h04,
    SRC_STRAPPED  = 5'h08,
    SRC_EEPROM    = 5'h10
  } cfg_source_e;

  // Reset sequencing state, one-hot.
  typedef enum logic [2:0] {
    ST_IN_RESET   = 3'h1,
    ST_SAMPLE     = 3'h2,
    ST_RUN        = 3'h4
  } seq_state_e;

  localparam logic [6:0] SMBUS_ADDR_A       = 7'h2C;
  localparam logic [6:0] SMBUS_ADDR_B       = 7'h2D;
  localparam logic [6:0] SMBUS_ADDR_RESET   = 7'h00;
  localparam cfg_source_e SOURCE_RESET      = SRC_DEFAULT;
  localparam int unsigned CLK_FREQ_MHZ      = 50;
  localparam int unsigned OSC_FREQ_MHZ      = 24;
  localparam int unsigned RESET_MIN_NS      = 1000;
  localparam int unsigned RESET_MIN_CYCLES  = (RESET_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned RST_CNT_W         = 6;

endpackage : cfg_select_pkg

// ### logic/hub_config_source_select.sv
`timescale 1ns/10ps
// Summary of operation
// - Select 00 gives SMBus slave, address 0101100.
// - Select 01 gives SMBus slave, address 0101101.
// - Select 10 gives defaults; bit2 adds straps.
// - Select 11 loads from serial EEPROM.
// - External reset is active low, holds chip.
// - Supply detect high means local power present.
// - 24MHz oscillator; crystal or external CMOS clock.
// - Select pins sampled at reset release.
// - Default mode samples straps at reset release.
module hub_config_source_select (
  // Clock and reset.
  input  wire logic                        clk_sys_in,
  input  wire logic                        reset_n_in,
  // Configuration select pins.
  input  wire logic                        cfg_source_bit0_in,
  input  wire logic                        cfg_source_bit1_in,
  input  wire logic                        cfg_source_bit2_in,
  // Strap pins.
  input  wire logic                        multi_translator_strap_in,
  input  wire logic                        gang_power_strap_in,
  input  wire logic                        local_supply_present_in,
  input  wire logic                        ext_clock_select_in,
  // Selection results.
  output logic                             chip_in_reset_out,
  output logic                             config_valid_out,
  output cfg_select_pkg::cfg_source_e      cfg_source_out,
  output logic                             smbus_slave_en_out,
  output logic [6:0]                       smbus_addr_out,
  output logic                             eeprom_load_en_out,
  output logic                             default_cfg_en_out,
  output logic                             strap_override_en_out,
  output logic                             multi_translator_en_out,
  output logic                             gang_power_en_out,
  output logic                             self_powered_out,
  output logic                             osc_driver_en_out,
  output logic                             reset_pulse_short_out
);
  import cfg_select_pkg::*;

  seq_state_e           state;
  seq_state_e           next_state;
  cfg_source_e          source;
  cfg_source_e          next_source;
  logic [6:0]           addr;
  logic [6:0]           next_addr;
  logic                 mtt;
  logic                 next_mtt;
  logic                 gang;
  logic                 next_gang;
  logic                 local_supply_present;
  logic                 next_local_supply_present;
  logic                 osc_drv;
  logic                 next_osc_drv;
  logic [RST_CNT_W-1:0] rst_cnt;
  logic [RST_CNT_W-1:0] next_rst_cnt;
  logic                 short_pulse;
  logic                 next_short_pulse;

  // Decoding happens in the cycle after release, from the pins seen in that same cycle.
  always_comb begin
    next_state       = state;
    next_source      = source;
    next_addr        = addr;
    next_mtt         = mtt;
    next_gang        = gang;
    next_local_supply_present    = local_supply_present;
    next_osc_drv     = osc_drv;
    next_rst_cnt     = rst_cnt;
    next_short_pulse = short_pulse;
    case (state)
      ST_IN_RESET: begin
        if (rst_cnt != RST_CNT_W'(RESET_MIN_CYCLES)) begin
          next_rst_cnt = rst_cnt + RST_CNT_W'(1);
        end
        next_state = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        // Flags a reset that ended before the board held it long enough.
        next_short_pulse = (rst_cnt < RST_CNT_W'(RESET_MIN_CYCLES));
        next_local_supply_present    = local_supply_present_in;
        next_osc_drv     = ~ext_clock_select_in;
        case ({cfg_source_bit1_in, cfg_source_bit0_in})
          2'b00: begin
            next_source = SRC_SMBUS_A;
            next_addr   = SMBUS_ADDR_A;
          end
          2'b01: begin
            next_source = SRC_SMBUS_B;
            next_addr   = SMBUS_ADDR_B;
          end
          2'b10: begin
            next_source = cfg_source_bit2_in ? SRC_STRAPPED : SRC_DEFAULT;
            next_addr   = SMBUS_ADDR_RESET;
          end
          default: begin
            next_source = SRC_EEPROM;
            next_addr   = SMBUS_ADDR_RESET;
          end
        endcase
        next_mtt   = multi_translator_strap_in;
        next_gang  = gang_power_strap_in;
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_IN_RESET;
      end
    endcase
  end

  // Reset low holds everything but the reset-length count; the second cycle high takes the samples.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state       <= ST_IN_RESET;
      short_pulse <= 1'b0;
      // The count restarts unless reset was already held, which covers the unknown power-up state.
      if (state == ST_IN_RESET) begin
        if (rst_cnt != RST_CNT_W'(RESET_MIN_CYCLES)) begin
          rst_cnt <= rst_cnt + RST_CNT_W'(1);
        end
      end else begin
        rst_cnt <= RST_CNT_W'(1);
      end
      source    <= SOURCE_RESET;
      addr      <= SMBUS_ADDR_RESET;
      mtt       <= 1'b0;
      gang      <= 1'b0;
      local_supply_present  <= 1'b0;
      osc_drv   <= 1'b1;
    end else begin
      state       <= next_state;
      short_pulse <= next_short_pulse;
      rst_cnt     <= (next_state == ST_RUN) ? next_rst_cnt : rst_cnt;
      source      <= next_source;
      addr        <= next_addr;
      mtt         <= next_mtt;
      gang        <= next_gang;
      local_supply_present    <= next_local_supply_present;
      osc_drv     <= next_osc_drv;
    end
  end

  // Output registers.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      chip_in_reset_out       <= 1'b1;
      config_valid_out        <= 1'b0;
      cfg_source_out          <= SOURCE_RESET;
      smbus_slave_en_out      <= 1'b0;
      smbus_addr_out          <= SMBUS_ADDR_RESET;
      eeprom_load_en_out      <= 1'b0;
      default_cfg_en_out      <= 1'b0;
      strap_override_en_out   <= 1'b0;
      multi_translator_en_out <= 1'b0;
      gang_power_en_out       <= 1'b0;
      self_powered_out        <= 1'b0;
      osc_driver_en_out       <= 1'b1;
      reset_pulse_short_out   <= 1'b0;
    end else begin
      chip_in_reset_out       <= (state != ST_RUN);
      config_valid_out        <= (state == ST_RUN);
      cfg_source_out          <= source;
      smbus_slave_en_out      <= (state == ST_RUN) && (source == SRC_SMBUS_A ||
                                                       source == SRC_SMBUS_B);
      smbus_addr_out          <= addr;
      eeprom_load_en_out      <= (state == ST_RUN) && (source == SRC_EEPROM);
      default_cfg_en_out      <= (state == ST_RUN) && (source == SRC_DEFAULT ||
                                                       source == SRC_STRAPPED);
      strap_override_en_out   <= (state == ST_RUN) && (source == SRC_STRAPPED);
      multi_translator_en_out <= mtt;
      gang_power_en_out       <= gang;
      self_powered_out        <= local_supply_present;
      osc_driver_en_out       <= osc_drv;
      reset_pulse_short_out   <= short_pulse;
    end
  end

  a_reset_holds_chip: assert property (@(posedge clk_sys_in)
    !reset_n_in |=> chip_in_reset_out && !config_valid_out)
    else $error("Chip not held while reset low.");

  sequence s_release;
    !reset_n_in ##1 reset_n_in [*3];
  endsequence

  a_smbus_addr_a: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 (reset_n_in && !cfg_source_bit1_in && !cfg_source_bit0_in)
     ##1 reset_n_in [*2]) |=> smbus_addr_out == 7'h2C && smbus_slave_en_out)
    else $error("Wrong SMBus slave address for select 00.");

  a_smbus_addr_b: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 (reset_n_in && !cfg_source_bit1_in && cfg_source_bit0_in)
     ##1 reset_n_in [*2]) |=> smbus_addr_out == 7'h2D && smbus_slave_en_out)
    else $error("Wrong SMBus slave address for select 01.");

  a_default_straps: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 (reset_n_in && cfg_source_bit1_in && !cfg_source_bit0_in)
     ##1 reset_n_in [*2]) |=>
    default_cfg_en_out && (strap_override_en_out == $past(cfg_source_bit2_in, 4)))
    else $error("Default configuration or strap override wrong.");

  a_eeprom_select: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 (reset_n_in && cfg_source_bit1_in && cfg_source_bit0_in)
     ##1 reset_n_in [*2]) |=> eeprom_load_en_out && !smbus_slave_en_out)
    else $error("EEPROM load not selected for select 11.");

  a_supply_sampled: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 reset_n_in [*4]) |->
    self_powered_out == $past(local_supply_present_in, 3))
    else $error("Local supply state not sampled at release.");

  a_osc_driver: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 reset_n_in [*4]) |->
    osc_driver_en_out == !$past(ext_clock_select_in, 3))
    else $error("Oscillator driver does not follow clock select.");

  a_strap_sampled: assert property (@(posedge clk_sys_in)
    (!reset_n_in ##1 reset_n_in [*4]) |->
    multi_translator_en_out == $past(multi_translator_strap_in, 3))
    else $error("Multi translator strap not sampled at release.");

  a_select_held: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (s_release ##1 reset_n_in) |=> $stable(cfg_source_out))
    else $error("Configuration source changed without reset.");

  a_short_reset_flag: assert property (@(posedge clk_sys_in)
    (reset_n_in ##1 !reset_n_in ##1 reset_n_in [*4]) |-> reset_pulse_short_out)
    else $error("One cycle reset not flagged as short.");

endmodule : hub_config_source_select

// ### tb/board_model.sv
`timescale 1ns/10ps
module board_model (
  // Levels the bench asks the board to strap.
  input  wire logic [2:0] code_in,
  input  wire logic [3:0] straps_in,
  input  wire logic       scramble_in,
  // Pins seen by the hub.
  output logic [2:0]      sel_out,
  output logic [3:0]      strap_out
);
  // Once sampled, the board may flip every pin and the hub must not follow.
  assign sel_out = scramble_in ? ~code_in : code_in;
  // Strap order is multi-translator, ganged power, local supply, external clock.
  assign strap_out = scramble_in ? ~straps_in : straps_in;
endmodule : board_model

// ### tb/hub_config_source_select_tb.sv
`timescale 1ns/10ps
module hub_config_source_select_tb;
  import cfg_select_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [2:0]  code       = 3'h0;
  logic [3:0]  straps     = 4'h0;
  logic        scramble   = 1'b0;
  wire  [2:0]  sel;
  wire  [3:0]  strap;
  wire         cfg_source_bit0_in = sel[0];
  wire         cfg_source_bit1_in = sel[1];
  wire         cfg_source_bit2_in = sel[2];
  wire         multi_translator_strap_in = strap[3];
  wire         gang_power_strap_in = strap[2];
  wire         local_supply_present_in = strap[1];
  wire         ext_clock_select_in = strap[0];
  logic        chip_in_reset_out, config_valid_out, smbus_slave_en_out, eeprom_load_en_out;
  logic        default_cfg_en_out, strap_override_en_out, multi_translator_en_out;
  logic        gang_power_en_out, self_powered_out, osc_driver_en_out, reset_pulse_short_out;
  cfg_source_e cfg_source_out;
  logic [6:0]  smbus_addr_out;
  int          fail_count = 0;
  int          n_checks   = 0;
  cfg_source_e exp;

  always #10 clk_sys_in = ~clk_sys_in;

  board_model brd (.code_in(code), .straps_in(straps), .scramble_in(scramble),
                   .sel_out(sel), .strap_out(strap));
  hub_config_source_select uut (
    .clk_sys_in                (clk_sys_in),
    .reset_n_in                (reset_n_in),
    .cfg_source_bit0_in        (cfg_source_bit0_in),
    .cfg_source_bit1_in        (cfg_source_bit1_in),
    .cfg_source_bit2_in        (cfg_source_bit2_in),
    .multi_translator_strap_in (multi_translator_strap_in),
    .gang_power_strap_in       (gang_power_strap_in),
    .local_supply_present_in   (local_supply_present_in),
    .ext_clock_select_in       (ext_clock_select_in),
    .chip_in_reset_out         (chip_in_reset_out),
    .config_valid_out          (config_valid_out),
    .cfg_source_out            (cfg_source_out),
    .smbus_slave_en_out        (smbus_slave_en_out),
    .smbus_addr_out            (smbus_addr_out),
    .eeprom_load_en_out        (eeprom_load_en_out),
    .default_cfg_en_out        (default_cfg_en_out),
    .strap_override_en_out     (strap_override_en_out),
    .multi_translator_en_out   (multi_translator_en_out),
    .gang_power_en_out         (gang_power_en_out),
    .self_powered_out          (self_powered_out),
    .osc_driver_en_out         (osc_driver_en_out),
    .reset_pulse_short_out     (reset_pulse_short_out)
  );

  task chk(input string name, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : wait_cyc

  // Straps change only while reset is low, then reset is released.
  task do_reset(input int low, input logic [2:0] c, input logic [3:0] s);
    reset_n_in = 1'b0;
    scramble   = 1'b0;
    wait_cyc(2);
    chk("in_reset", 8'h01, {7'h00, chip_in_reset_out});
    chk("valid_low", 8'h00, {7'h00, config_valid_out});
    code   = c;
    straps = s;
    wait_cyc(low - 2);
    reset_n_in = 1'b1;
    wait_cyc(3);
  endtask : do_reset

  initial begin
    wait_cyc(20);
    for (int i = 0; i < 8; i++) begin
      do_reset(60, i[2:0], {i[2], ~i[2], i[1], i[0]});
      case (i[1:0])
        2'h0: exp = SRC_SMBUS_A;
        2'h1: exp = SRC_SMBUS_B;
        2'h2: exp = i[2] ? SRC_STRAPPED : SRC_DEFAULT;
        default: exp = SRC_EEPROM;
      endcase
      chk("source", {3'h0, exp}, {3'h0, cfg_source_out});
      chk("addr", {1'b0, i[1] ? 7'h00 : (i[0] ? 7'h2D : 7'h2C)}, {1'b0, smbus_addr_out});
      chk("smbus_en", {7'h00, ~i[1]}, {7'h00, smbus_slave_en_out});
      chk("eeprom_en", {7'h00, i[1] & i[0]}, {7'h00, eeprom_load_en_out});
      chk("default_en", {7'h00, i[1] & ~i[0]}, {7'h00, default_cfg_en_out});
      chk("override_en", {7'h00, i == 6}, {7'h00, strap_override_en_out});
      chk("local_supply_present", {7'h00, i[1]}, {7'h00, self_powered_out});
      chk("osc_drv", {7'h00, ~i[0]}, {7'h00, osc_driver_en_out});
      chk("valid", 8'h01, {7'h00, config_valid_out});
      chk("run", 8'h00, {7'h00, chip_in_reset_out});
      chk("short", 8'h00, {7'h00, reset_pulse_short_out});
      if (i[1:0] == 2'h2) begin
        chk("mtt", {7'h00, i[2]}, {7'h00, multi_translator_en_out});
        chk("gang", {7'h00, ~i[2]}, {7'h00, gang_power_en_out});
      end
      scramble = 1'b1;
      wait_cyc(5);
      chk("held", {3'h0, exp}, {3'h0, cfg_source_out});
    end
    do_reset(10, 3'h3, 4'h0);
    chk("short_seen", 8'h01, {7'h00, reset_pulse_short_out});
    // A single low cycle must still restart the hub and be flagged as short.
    reset_n_in = 1'b0;
    wait_cyc(1);
    reset_n_in = 1'b1;
    wait_cyc(3);
    chk("short_one", 8'h01, {7'h00, reset_pulse_short_out});
    chk("source_one", {3'h0, SRC_EEPROM}, {3'h0, cfg_source_out});
    wait_cyc(2);
    results();
  end

  initial begin
    repeat (3000) @(posedge clk_sys_in);
    fail_count++;
    results();
  end
endmodule : hub_config_source_select_tb
